// ==== rtl/pmi_dev.sv ====
// Device end: serial management slave, interrupt pin and lamp straps
`timescale 1ns/10ps
`default_nettype none
module pmi_dev (
   input  wire logic                         CLK_SYS_I,
   input  wire logic                         RESET_I,
   input  wire logic [pmi_pkg::DATA_W-1:0]   EVENT_I,
   input  wire logic [pmi_pkg::LAMP_N-1:0]   LAMP_ACT_I,
   input  wire logic [pmi_pkg::ADDR_W-1:0]   PHY_ADDR_I,
   output logic      [pmi_pkg::LAMP_N-1:0]   STRAP_O,
   output logic                              STRAP_VALID_O,
   output logic                              IRQ_ACTIVE_O,
   pmi_if.dev                                LINK
);
   import pmi_pkg::*;

   // ****************************************************
   // Link clock domain
   // ****************************************************
   pmi_dev_state_t st;
   logic              mdc_run;
   logic [ADDR_W-1:0] addr_m;
   logic [DATA_W-1:0] istat_m;
   logic [5:0]        ones;
   logic [3:0]        cnt;
   logic [11:0]       hdr;
   logic              rd;
   logic [ADDR_W-1:0] reg_a;
   logic [DATA_W-1:0] sh;
   logic              mdio_out;
   logic              mdio_oe;
   logic [DATA_W-1:0] imask;
   logic [5:0]        lamp_cfg;
   logic [DATA_W-1:0] clr_bits;
   logic              clr_tgl;
   logic [DATA_W-1:0] sticky;
   logic              cfg_tgl;

   pmi_sync #(.W(1)) u_rst_mdc (
      .clk_i (LINK.mdc),
      .rst_i (RESET_I),
      .d_i   (1'b1),
      .q_o   (mdc_run)
   );
   pmi_sync #(.W(ADDR_W)) u_addr (
      .clk_i (LINK.mdc),
      .rst_i (RESET_I),
      .d_i   (PHY_ADDR_I),
      .q_o   (addr_m)
   );
   pmi_sync #(.W(DATA_W)) u_istat (
      .clk_i (LINK.mdc),
      .rst_i (RESET_I),
      .d_i   (sticky),
      .q_o   (istat_m)
   );

   wire              mdc_rst   = ~mdc_run;
   wire              bit_in    = LINK.mdio;
   wire [12:0]       hdr_full  = {hdr, bit_in};
   wire [1:0]        hdr_op    = hdr_full[11:10];
   wire [ADDR_W-1:0] hdr_pa    = hdr_full[9:5];
   wire [ADDR_W-1:0] hdr_ra    = hdr_full[4:0];
   wire              op_ok     = (hdr_op == OP_READ) || (hdr_op == OP_WRITE);
   wire              hdr_ok    = hdr_full[12] && (hdr_pa == addr_m) && op_ok;
   wire [DATA_W-1:0] wdata     = {sh[DATA_W-2:0], bit_in};
   wire              is_istat  = (reg_a == REG_ISTAT);
   wire              is_cfg    = (reg_a == REG_IMASK) || (reg_a == REG_LAMP);
   wire [DATA_W-1:0] rd_word   = (reg_a == REG_IMASK) ? imask :
                                 (reg_a == REG_LAMP)  ? {10'h000, lamp_cfg} :
                                 is_istat             ? istat_m : 16'h0000;

   // Frame decoder, sampled on every rising link clock edge
   always_ff @(posedge LINK.mdc or posedge mdc_rst) begin
      if (mdc_rst) begin
         st       <= S_IDLE;
         ones     <= 6'h00;
         cnt      <= 4'h0;
         hdr      <= 12'h000;
         rd       <= 1'b0;
         reg_a    <= 5'h00;
         sh       <= 16'h0000;
         mdio_out <= 1'b0;
         mdio_oe  <= 1'b0;
         imask    <= IMASK_RST;
         lamp_cfg <= LAMP_RST;
         clr_bits <= 16'h0000;
         clr_tgl  <= 1'b0;
         cfg_tgl  <= 1'b0;
      end else begin
         case (st)
            S_IDLE: begin
               if (bit_in) begin
                  ones <= (ones == PREAMBLE_BITS) ? ones : ones + 6'h01;
               end else begin
                  ones <= 6'h00;
                  if (ones == PREAMBLE_BITS) begin
                     st  <= S_HDR;
                     cnt <= 4'h0;
                  end
               end
            end
            S_HDR: begin
               hdr <= hdr_full[11:0];
               cnt <= cnt + 4'h1;
               if (cnt == HDR_LAST) begin
                  cnt   <= 4'h0;
                  rd    <= (hdr_op == OP_READ);
                  reg_a <= hdr_ra;
                  st    <= hdr_ok ? S_TA : S_IDLE;
               end
            end
            S_TA: begin
               cnt <= cnt + 4'h1;
               if (cnt == 4'h0) begin
                  if (rd) begin
                     mdio_oe  <= 1'b1;
                     mdio_out <= 1'b0;
                     sh       <= rd_word;
                     clr_bits <= is_istat ? istat_m : 16'h0000;
                  end
               end else begin
                  st  <= S_DATA;
                  cnt <= 4'h0;
                  if (rd) begin
                     mdio_out <= sh[DATA_W-1];
                     sh       <= {sh[DATA_W-2:0], 1'b0};
                  end
               end
            end
            S_DATA: begin
               cnt <= cnt + 4'h1;
               if (rd) begin
                  mdio_out <= sh[DATA_W-1];
                  sh       <= {sh[DATA_W-2:0], 1'b0};
               end else begin
                  sh <= wdata;
               end
               if (cnt == DATA_LAST) begin
                  st       <= S_IDLE;
                  mdio_oe  <= 1'b0;
                  mdio_out <= 1'b0;
                  if (rd && is_istat) begin
                     clr_tgl <= ~clr_tgl;
                  end
                  if (!rd && reg_a == REG_IMASK) begin
                     imask <= wdata;
                  end
                  if (!rd && reg_a == REG_LAMP) begin
                     lamp_cfg <= wdata[5:0];
                  end
                  if (!rd && is_cfg) begin
                     cfg_tgl <= ~cfg_tgl;
                  end
               end
            end
            default: begin
               st <= S_IDLE;
            end
         endcase
      end
   end

   assign LINK.dev_mdio_o  = mdio_out;
   assign LINK.dev_mdio_oe = mdio_oe;
   assign LINK.dev_mdio_pu = ~mdio_oe;

   // ****************************************************
   // System clock domain
   // ****************************************************
   logic [DATA_W+5:0]  cfg_s;
   logic               clr_s;
   logic               clr_d;
   logic               cfg_ts;
   logic               cfg_td;
   logic [LAMP_N:0]    pin_s;
   logic [2:0]         strap_cnt;
   logic               strap_done;
   logic               irq_idle;
   logic [LAMP_N-1:0]  lamp_val;

   // Settings word held still; only its toggle is synchronised
   pmi_sync #(.W(1)) u_cfg (
      .clk_i (CLK_SYS_I),
      .rst_i (RESET_I),
      .d_i   (cfg_tgl),
      .q_o   (cfg_ts)
   );
   pmi_sync #(.W(1)) u_clr (
      .clk_i (CLK_SYS_I),
      .rst_i (RESET_I),
      .d_i   (clr_tgl),
      .q_o   (clr_s)
   );
   pmi_sync #(.W(LAMP_N + 1)) u_pins (
      .clk_i (CLK_SYS_I),
      .rst_i (RESET_I),
      .d_i   ({LINK.irq_line, LINK.lamp_line}),
      .q_o   (pin_s)
   );

   wire [DATA_W-1:0] mask_s      = cfg_s[DATA_W+5:6];
   wire [5:0]        lamp_s      = cfg_s[5:0];
   wire              clr_evt     = clr_s ^ clr_d;
   wire              cfg_evt     = cfg_ts ^ cfg_td;
   wire              strap_end   = !strap_done && (strap_cnt == STRAP_LAST);
   wire [DATA_W-1:0] ready_set   = strap_end ? ISTAT_READY : 16'h0000;
   wire [DATA_W-1:0] clr_mask    = clr_evt ? clr_bits : 16'h0000;
   // New events win over a clear in the same cycle
   wire [DATA_W-1:0] next_sticky = (sticky & ~clr_mask) | EVENT_I | ready_set;
   wire              irq_pend    = |(sticky & mask_s);

   generate
      for (genvar i = 0; i < LAMP_N; i++) begin : g_lamp
         wire [1:0] mode = lamp_s[2*i+1:2*i];
         assign lamp_val[i] = (mode == LAMP_OFF) ? 1'b0 :
                              (mode == LAMP_ON)  ? 1'b1 :
                              (mode == LAMP_IRQ) ? irq_pend : LAMP_ACT_I[i];
      end
   endgenerate

   // Settings copied once their toggle has crossed
   always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
      if (RESET_I) begin
         cfg_td <= 1'b0;
         cfg_s  <= {IMASK_RST, LAMP_RST};
      end else begin
         cfg_td <= cfg_ts;
         if (cfg_evt) begin
            cfg_s <= {imask, lamp_cfg};
         end
      end
   end

   // Straps caught just after release while every pin still floats
   always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
      if (RESET_I) begin
         strap_cnt     <= 3'h0;
         strap_done    <= 1'b0;
         STRAP_O       <= 3'h0;
         STRAP_VALID_O <= 1'b0;
         irq_idle      <= 1'b0;
      end else if (strap_end) begin
         strap_done    <= 1'b1;
         STRAP_O       <= pin_s[LAMP_N-1:0];
         STRAP_VALID_O <= 1'b1;
         irq_idle      <= pin_s[LAMP_N];
      end else if (!strap_done) begin
         strap_cnt <= strap_cnt + 3'h1;
      end
   end

   always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
      if (RESET_I) begin
         sticky           <= 16'h0000;
         clr_d            <= 1'b0;
         IRQ_ACTIVE_O     <= 1'b0;
         LINK.dev_irq_o   <= 1'b0;
         LINK.dev_irq_oe  <= 1'b0;
         LINK.dev_lamp_o  <= 3'h0;
         LINK.dev_lamp_oe <= 3'h0;
      end else begin
         sticky           <= next_sticky;
         clr_d            <= clr_s;
         IRQ_ACTIVE_O     <= strap_done && irq_pend;
         LINK.dev_irq_oe  <= strap_done && irq_pend;
         LINK.dev_irq_o   <= ~irq_idle;
         LINK.dev_lamp_o  <= lamp_val;
         LINK.dev_lamp_oe <= {LAMP_N{strap_done}};
      end
   end
endmodule
`default_nettype wire

// ==== rtl/pmi_host.sv ====
// Host end: management clock source and frame master
`timescale 1ns/10ps
`default_nettype none
module pmi_host (
   input  wire logic                         CLK_SYS_I,
   input  wire logic                         RESET_I,
   input  wire logic                         REQ_VALID_I,
   output logic                              REQ_READY_O,
   input  wire logic                         REQ_WRITE_I,
   input  wire logic [pmi_pkg::ADDR_W-1:0]   REQ_PHY_I,
   input  wire logic [pmi_pkg::ADDR_W-1:0]   REQ_REG_I,
   input  wire logic [pmi_pkg::DATA_W-1:0]   REQ_WDATA_I,
   output logic                              RSP_VALID_O,
   output logic      [pmi_pkg::DATA_W-1:0]   RSP_RDATA_O,
   input  wire logic                         IRQ_ACTIVE_LOW_I,
   output logic                              IRQ_O,
   pmi_if.host                               LINK
);
   import pmi_pkg::*;

   pmi_host_state_t st;
   logic [2:0]        div;
   logic [6:0]        bitcnt;
   logic [63:0]       frame;
   logic              rd;
   logic [DATA_W-1:0] rsh;
   logic [1:0]        line_s;
   logic [1:0]        warm;

   pmi_sync #(.W(2)) u_line (
      .clk_i (CLK_SYS_I),
      .rst_i (RESET_I),
      .d_i   ({LINK.mdio, LINK.irq_line}),
      .q_o   (line_s)
   );

   wire       mdio_s    = line_s[1];
   wire [2:0] next_div  = (div == MDC_LAST) ? 3'h0 : div + 3'h1;
   // Data changes one system cycle after the clock rises
   wire       drive_now = (div == 3'h0);
   wire       accept    = (st == H_IDLE) && REQ_VALID_I;
   wire [1:0] op        = REQ_WRITE_I ? OP_WRITE : OP_READ;
   wire       last_bit  = (bitcnt == FRAME_BITS);

   assign REQ_READY_O = (st == H_IDLE);

   // Free-running divided management clock
   always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
      if (RESET_I) begin
         div      <= 3'h0;
         LINK.mdc <= 1'b0;
      end else begin
         div      <= next_div;
         LINK.mdc <= (next_div < MDC_HALF);
      end
   end

   // Frame shifter
   always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
      if (RESET_I) begin
         st                <= H_IDLE;
         bitcnt            <= 7'h00;
         frame             <= 64'h0;
         rd                <= 1'b0;
         rsh               <= 16'h0000;
         RSP_VALID_O       <= 1'b0;
         RSP_RDATA_O       <= 16'h0000;
         LINK.host_mdio_o  <= 1'b0;
         LINK.host_mdio_oe <= 1'b0;
      end else begin
         RSP_VALID_O <= 1'b0;
         case (st)
            H_IDLE: begin
               if (accept) begin
                  st     <= H_BUSY;
                  bitcnt <= 7'h00;
                  rd     <= !REQ_WRITE_I;
                  frame  <= {32'hffff_ffff, START_CODE, op, REQ_PHY_I, REQ_REG_I,
                             TA_WRITE, REQ_WDATA_I};
               end
            end
            H_BUSY: begin
               if (drive_now) begin
                  rsh <= {rsh[DATA_W-2:0], mdio_s};
                  if (last_bit) begin
                     st                <= H_IDLE;
                     LINK.host_mdio_oe <= 1'b0;
                     LINK.host_mdio_o  <= 1'b0;
                     RSP_VALID_O       <= 1'b1;
                     if (rd) begin
                        RSP_RDATA_O <= {rsh[DATA_W-2:0], mdio_s};
                     end
                  end else begin
                     bitcnt            <= bitcnt + 7'h01;
                     frame             <= {frame[62:0], 1'b0};
                     LINK.host_mdio_o  <= frame[63];
                     LINK.host_mdio_oe <= !(rd && bitcnt >= TA_POS);
                  end
               end
            end
            default: begin
               st <= H_IDLE;
            end
         endcase
      end
   end

   // Interrupt line seen through the chosen resistor polarity
   always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
      if (RESET_I) begin
         warm  <= 2'h0;
         IRQ_O <= 1'b0;
      end else begin
         warm  <= {warm[0], 1'b1};
         // Synchroniser shows reset zeros for two cycles
         IRQ_O <= warm[1] && (line_s[0] ^ IRQ_ACTIVE_LOW_I);
      end
   end
endmodule
`default_nettype wire

// ==== rtl/pmi_if.sv ====
// Management link wires between host end and device end
`timescale 1ns/10ps
`default_nettype none
interface pmi_if;
   logic       mdc;
   logic       host_mdio_o;
   logic       host_mdio_oe;
   logic       dev_mdio_o;
   logic       dev_mdio_oe;
   logic       dev_mdio_pu;
   logic       mdio;
   logic       dev_irq_o;
   logic       dev_irq_oe;
   logic       irq_pull_up;
   logic       irq_line;
   logic [2:0] dev_lamp_o;
   logic [2:0] dev_lamp_oe;
   logic [2:0] lamp_strap;
   logic [2:0] lamp_line;

   // Undriven data line rests high through the pull-up
   assign mdio      = host_mdio_oe ? host_mdio_o : (dev_mdio_oe ? dev_mdio_o : 1'b1);
   assign irq_line  = dev_irq_oe ? dev_irq_o : irq_pull_up;
   assign lamp_line = (dev_lamp_o & dev_lamp_oe) | (lamp_strap & ~dev_lamp_oe);

   modport host (
      output mdc,
      output host_mdio_o,
      output host_mdio_oe,
      input  mdio,
      input  irq_line
   );
   modport dev (
      input  mdc,
      input  mdio,
      output dev_mdio_o,
      output dev_mdio_oe,
      output dev_mdio_pu,
      input  irq_line,
      output dev_irq_o,
      output dev_irq_oe,
      input  lamp_line,
      output dev_lamp_o,
      output dev_lamp_oe
   );
endinterface
`default_nettype wire

// ==== rtl/pmi_pkg.sv ====
// Constants and types shared by both ends of the serial management link
// Operation
// - Frames follow clause 22 station-management structure
// - Host supplies the management clock
// - Data line changes only while clock is high
// - Device captures data line at clock rise
// - Host sends command, address, write data
// - Device pull-up on only while line is input
// - Interrupt pin floats while nothing is pending
// - Interrupt drives opposite to external resistor
// - Interrupt events selectable by mask register
// - Interrupt asserts after reset: device ready
// - Status read clears interrupt indication
// - Several interrupt pins may share wired-OR
// - Three lamp pins sampled as straps
// - Lamp pins then configurable outputs
`default_nettype none
package pmi_pkg;
   localparam int          DATA_W         = 16;
   localparam int          ADDR_W         = 5;
   localparam int          LAMP_N         = 3;
   localparam logic [5:0]  PREAMBLE_BITS  = 6'h20;
   localparam logic [1:0]  START_CODE     = 2'h1;
   localparam logic [1:0]  OP_READ        = 2'h2;
   localparam logic [1:0]  OP_WRITE       = 2'h1;
   localparam logic [1:0]  TA_WRITE       = 2'h2;
   localparam logic [3:0]  HDR_LAST       = 4'hc;
   localparam logic [3:0]  DATA_LAST      = 4'hf;
   localparam logic [6:0]  FRAME_BITS     = 7'h40;
   localparam logic [6:0]  TA_POS         = 7'h2e;
   localparam logic [4:0]  REG_LAMP       = 5'h10;
   localparam logic [4:0]  REG_IMASK      = 5'h19;
   localparam logic [4:0]  REG_ISTAT      = 5'h1a;
   localparam logic [15:0] IMASK_RST      = 16'h0001;
   localparam logic [15:0] ISTAT_READY    = 16'h0001;
   localparam logic [5:0]  LAMP_RST       = 6'h00;
   localparam logic [1:0]  LAMP_OFF       = 2'h0;
   localparam logic [1:0]  LAMP_ON        = 2'h1;
   localparam logic [1:0]  LAMP_IRQ       = 2'h2;
   localparam logic [2:0]  STRAP_LAST     = 3'h3;
   localparam int          SYS_PERIOD_NS  = 8;
   localparam int          MDC_PERIOD_NS  = 64;
   localparam logic [2:0]  MDC_HALF       = 3'(MDC_PERIOD_NS / (2 * SYS_PERIOD_NS));
   localparam logic [2:0]  MDC_LAST       = 3'(MDC_PERIOD_NS / SYS_PERIOD_NS - 1);
   typedef enum logic [1:0] {S_IDLE, S_HDR, S_TA, S_DATA} pmi_dev_state_t;
   typedef enum logic {H_IDLE, H_BUSY} pmi_host_state_t;
endpackage
`default_nettype wire

// ==== rtl/pmi_sync.sv ====
// Two-stage synchroniser for levels entering a clock domain
`timescale 1ns/10ps
`default_nettype none
module pmi_sync #(
   parameter int W = 1
) (
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   logic [W-1:0] meta;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         meta <= '0;
         q_o  <= '0;
      end else begin
         meta <= d_i;
         q_o  <= meta;
      end
   end
endmodule
`default_nettype wire

// ==== verif/phy_mgmt_serial_and_irq_tb.sv ====
// Self-checking bench for both ends of the management link
`timescale 1ns/10ps
`default_nettype none
module phy_mgmt_serial_and_irq_tb;
   import pmi_pkg::*;
   localparam logic [4:0] DEV_ADDR = 5'h03;
   logic        clk_sys;
   logic        reset;
   logic        req_valid;
   logic        req_ready;
   logic        req_write;
   logic [4:0]  req_phy;
   logic [4:0]  req_reg;
   logic [15:0] req_wdata;
   logic        rsp_valid;
   logic [15:0] rsp_rdata;
   logic        irq;
   logic [15:0] event_in;
   logic [2:0]  lamp_act;
   logic [2:0]  strap;
   logic        strap_valid;
   logic        irq_active;
   logic [63:0] frame_sh;
   logic [15:0] rd;
   int          err_count;
   int          comparisons;
   pmi_if link_if();
   pmi_dev pmi_dev_inst (.CLK_SYS_I(clk_sys), .RESET_I(reset), .EVENT_I(event_in),
      .LAMP_ACT_I(lamp_act), .PHY_ADDR_I(DEV_ADDR), .STRAP_O(strap),
      .STRAP_VALID_O(strap_valid), .IRQ_ACTIVE_O(irq_active), .LINK(link_if));
   pmi_host pmi_host_inst (.CLK_SYS_I(clk_sys), .RESET_I(reset), .REQ_VALID_I(req_valid),
      .REQ_READY_O(req_ready), .REQ_WRITE_I(req_write), .REQ_PHY_I(req_phy),
      .REQ_REG_I(req_reg), .REQ_WDATA_I(req_wdata), .RSP_VALID_O(rsp_valid),
      .RSP_RDATA_O(rsp_rdata), .IRQ_ACTIVE_LOW_I(link_if.irq_pull_up), .IRQ_O(irq),
      .LINK(link_if));
   pmi_chk pmi_chk_inst (.CLK_SYS_I(clk_sys), .RESET_I(reset), .mdc(link_if.mdc),
      .host_mdio_o(link_if.host_mdio_o), .host_mdio_oe(link_if.host_mdio_oe),
      .dev_mdio_o(link_if.dev_mdio_o), .dev_mdio_oe(link_if.dev_mdio_oe),
      .dev_mdio_pu(link_if.dev_mdio_pu), .dev_irq_o(link_if.dev_irq_o),
      .dev_irq_oe(link_if.dev_irq_oe), .irq_pull_up(link_if.irq_pull_up),
      .dev_lamp_oe(link_if.dev_lamp_oe));
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   // Wire bits as the device sees them
   always @(posedge link_if.mdc) frame_sh <= {frame_sh[62:0], link_if.mdio};
   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic report_and_stop;
      $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic mgmt_op(input logic wr, input logic [4:0] phy, input logic [4:0] rg,
                          input logic [15:0] wd, output logic [15:0] data);
      int n;
      logic [63:0] exp_frame;
      req_valid <= 1'b1;
      req_write <= wr;
      req_phy   <= phy;
      req_reg   <= rg;
      req_wdata <= wd;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (req_ready !== 1'b1 && n < 20);
      req_valid <= 1'b0;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (rsp_valid !== 1'b1 && n < 600);
      check("response", rsp_valid, 1'b1);
      data = rsp_rdata;
      exp_frame = {32'hffffffff, START_CODE, OP_WRITE, phy, rg, TA_WRITE, wd};
      if (wr) check("frame", frame_sh, exp_frame);
   endtask
   task automatic pulse(input logic [15:0] ev);
      event_in <= ev;
      @(posedge clk_sys);
      event_in <= 16'h0;
      repeat (20) @(posedge clk_sys);
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_boot(input logic pu, input logic [2:0] pins);
      reset <= 1'b1;
      link_if.irq_pull_up <= pu;
      link_if.lamp_strap  <= pins;
      repeat (16) @(posedge clk_sys);
      reset <= 1'b0;
      repeat (40) @(posedge clk_sys);
      check("strap", strap, pins);
      check("strap valid", strap_valid, 1'b1);
      check("ready irq", irq_active, 1'b1);
      check("irq pin", link_if.irq_line, !pu);
      check("host irq", irq, 1'b1);
      check("lamps off", link_if.lamp_line, 3'h0);
   endtask
   task automatic t_clear(input logic [15:0] exp);
      mgmt_op(1'b0, DEV_ADDR, REG_ISTAT, 16'h0, rd);
      check("status", rd, exp);
      repeat (10) @(posedge clk_sys);
      check("irq cleared", irq_active, 1'b0);
      check("irq floats", link_if.irq_line, link_if.irq_pull_up);
      check("host irq off", irq, 1'b0);
      mgmt_op(1'b0, DEV_ADDR, REG_ISTAT, 16'h0, rd);
      check("status empty", rd, 16'h0);
   endtask
   task automatic t_events;
      logic [2:0] exp [4] = '{3'h0, 3'h7, 3'h7, 3'h6};
      mgmt_op(1'b1, DEV_ADDR, REG_IMASK, 16'h0004, rd);
      mgmt_op(1'b0, DEV_ADDR, REG_IMASK, 16'h0, rd);
      check("mask", rd, 16'h0004);
      pulse(16'h0008);
      check("masked event", irq_active, 1'b0);
      pulse(16'h0004);
      check("enabled event", irq_active, 1'b1);
      check("host irq", irq, 1'b1);
      for (int m = 0; m < 4; m++) begin
         mgmt_op(1'b1, DEV_ADDR, REG_LAMP, {10'h0, {3{m[1:0]}}}, rd);
         repeat (10) @(posedge clk_sys);
         check("lamp mode", link_if.lamp_line, exp[m]);
      end
      mgmt_op(1'b0, DEV_ADDR, REG_LAMP, 16'h0, rd);
      check("lamp config", rd, 16'h003f);
      mgmt_op(1'b1, DEV_ADDR, REG_ISTAT, 16'hffff, rd);
      t_clear(16'h000c);
   endtask
   task automatic t_bad_addr;
      mgmt_op(1'b0, DEV_ADDR ^ 5'h01, REG_IMASK, 16'h0, rd);
      check("foreign address", rd, 16'hffff);
      mgmt_op(1'b0, DEV_ADDR, REG_IMASK, 16'h0, rd);
      check("mask after foreign", rd, 16'h0004);
   endtask
   initial begin
      // Reset rises by the first boot so every async reset sees an edge
      reset = 1'b0;
      req_valid = 1'b0;
      req_write = 1'b0;
      req_phy = 5'h0;
      req_reg = 5'h0;
      req_wdata = 16'h0;
      event_in = 16'h0;
      lamp_act = 3'h6;
      link_if.irq_pull_up = 1'b1;
      link_if.lamp_strap = 3'h5;
      err_count = 0;
      comparisons = 0;
      t_boot(1'b1, 3'h5);
      t_clear(16'h0001);
      t_events;
      t_bad_addr;
      t_boot(1'b0, 3'h2);
      t_clear(16'h0001);
      report_and_stop();
   end
   initial begin
      repeat (40000) @(posedge clk_sys);
      err_count++;
      report_and_stop();
   end
endmodule
`default_nettype wire

// ==== verif/pmi_chk.sv ====
// Assertion checker for the management link between host and device ends
`timescale 1ns/10ps
`default_nettype none
module pmi_chk (
   input  wire logic       CLK_SYS_I,
   input  wire logic       RESET_I,
   input  wire logic       mdc,
   input  wire logic       host_mdio_o,
   input  wire logic       host_mdio_oe,
   input  wire logic       dev_mdio_o,
   input  wire logic       dev_mdio_oe,
   input  wire logic       dev_mdio_pu,
   input  wire logic       dev_irq_o,
   input  wire logic       dev_irq_oe,
   input  wire logic       irq_pull_up,
   input  wire logic [2:0] dev_lamp_oe
);
   // ****************************************
   // Properties
   // ****************************************
   property p_pu_off;
      @(posedge CLK_SYS_I) disable iff (RESET_I) dev_mdio_pu == !dev_mdio_oe;
   endproperty
   property p_one_driver;
      @(posedge CLK_SYS_I) disable iff (RESET_I) !(host_mdio_oe && dev_mdio_oe);
   endproperty
   property p_dev_edge;
      @(posedge CLK_SYS_I) disable iff (RESET_I)
         dev_mdio_oe && $changed(dev_mdio_o) |-> $rose(mdc);
   endproperty
   property p_host_edge;
      @(posedge CLK_SYS_I) disable iff (RESET_I)
         host_mdio_oe && $changed(host_mdio_o) |-> mdc && !$past(mdc, 2);
   endproperty
   property p_irq_level;
      @(posedge CLK_SYS_I) disable iff (RESET_I) dev_irq_oe |-> dev_irq_o == !irq_pull_up;
   endproperty
   property p_ready_irq;
      @(posedge CLK_SYS_I) disable iff (RESET_I) $fell(RESET_I) |-> ##[1:20] dev_irq_oe;
   endproperty
   property p_lamp_boot;
      @(posedge CLK_SYS_I) disable iff (RESET_I)
         $fell(RESET_I) |-> dev_lamp_oe == 3'h0 ##[1:12] dev_lamp_oe == 3'h7;
   endproperty
   property p_reset_quiet;
      @(posedge CLK_SYS_I) RESET_I |-> !dev_mdio_oe && !dev_irq_oe && dev_lamp_oe == 3'h0;
   endproperty
   // Turnaround zero, then sixteen data bits, then release
   property p_read_burst;
      @(posedge mdc) disable iff (RESET_I) $rose(dev_mdio_oe) |-> (!dev_mdio_o && dev_mdio_oe)
         ##1 dev_mdio_oe[*7] ##1 dev_mdio_oe[*8] ##1 dev_mdio_oe ##1 !dev_mdio_oe;
   endproperty
   // ****************************************
   // Assertions and covers
   // ****************************************
   a_pu_off: assert property (p_pu_off) else $error("pull-up wrong");
   a_one_driver: assert property (p_one_driver) else $error("two drivers");
   a_dev_edge: assert property (p_dev_edge) else $error("device data off edge");
   a_host_edge: assert property (p_host_edge) else $error("host data off edge");
   a_irq_level: assert property (p_irq_level) else $error("irq polarity wrong");
   a_ready_irq: assert property (p_ready_irq) else $error("no ready irq");
   a_lamp_boot: assert property (p_lamp_boot) else $error("lamp pins wrong");
   a_reset_quiet: assert property (p_reset_quiet) else $error("driving in reset");
   a_read_burst: assert property (p_read_burst) else $error("read burst length");
   c_read: cover property (@(posedge mdc) $rose(dev_mdio_oe));
   c_irq_clear: cover property (@(posedge CLK_SYS_I) $fell(dev_irq_oe));
   c_host_frame: cover property (@(posedge CLK_SYS_I) $fell(host_mdio_oe));
endmodule
`default_nettype wire
